// ### rtl/psm_port_mux.v
// Port A to D line multiplexer with its configuration registers.
// Assumes pins and peripheral signals are synchronous to clk; ports are packed
// as {D,C,B,A}, 32 bits each, line n of port p at bit 32*p+n.
`timescale 1ns/1ps
`include "psm_port_mux_consts.vh"

module psm_port_mux #(
	parameter LATE_REV = 1
)(
	input wire clk,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrEn,
	input wire regRdEn,
	output reg [31:0] regRdData,
	input wire powerOnResetN,
	input wire [127:0] pinIn,
	output wire [127:0] pinOut,
	output wire [127:0] pinOe,
	input wire [127:0] periphOut,
	input wire [127:0] periphOe,
	output wire [127:0] periphIn,
	input wire [127:0] altOut,
	input wire [127:0] altOe,
	output wire [127:0] altIn,
	output reg [31:0] irqLine,
	output reg nmiLine
);

////////////////////////////////////////////////////////////////////////////////

// Line capability per revision
localparam [31:0] IMPL_D = LATE_REV ? `PSM_IMPL_D_LATE : `PSM_IMPL_D_EARLY;
localparam [31:0] GPIO_B = LATE_REV ? `PSM_GPIO_B_LATE : `PSM_GPIO_B_EARLY;
localparam [31:0] GPIO_C = LATE_REV ? `PSM_GPIO_C_LATE : `PSM_GPIO_C_EARLY;
localparam [31:0] GPIO_D = LATE_REV ? `PSM_GPIO_D_LATE : `PSM_GPIO_D_EARLY;
localparam [31:0] STRAP_D = LATE_REV ? `PSM_STRAP_D_LATE : `PSM_STRAP_D_EARLY;
localparam [127:0] IMPL_MASK = {IMPL_D, `PSM_IMPL_C, `PSM_IMPL_B, `PSM_IMPL_A};
localparam [127:0] GPIO_MASK = {GPIO_D, GPIO_C, GPIO_B, `PSM_GPIO_A};
localparam [127:0] ALT_MASK = {`PSM_ALT_D, 32'h00000000, 32'h00000000, `PSM_ALT_A};
localparam [127:0] STRAP_MASK = {STRAP_D, `PSM_STRAP_C, `PSM_STRAP_B, `PSM_STRAP_A};

////////////////////////////////////////////////////////////////////////////////

reg [127:0] ctrlSel_q;
reg [127:0] lineDir_q;
reg [127:0] dataOut_q;
reg [31:0] irqEnA_q;
reg portaAltSel_q;
reg portdAltSel_q;
reg [127:0] strap_q;
reg porPrev_q;

wire [127:0] pinValue;
wire [31:0] irqNext;
reg [31:0] rdWord;

// Writes land at the edge; routing below is combinational from these flops,
// so the new setting is on the pins in the following cycle.
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		ctrlSel_q <= {4{`PSM_RST_WORD}};
		lineDir_q <= {4{`PSM_RST_WORD}};
		dataOut_q <= {4{`PSM_RST_WORD}};
		irqEnA_q <= `PSM_RST_WORD;
		portaAltSel_q <= 1'b0;
		portdAltSel_q <= 1'b0;
	end
	else if (regWrEn)
	begin
		case (regAddr)
		`PSM_OFS_CTRL_A:
		begin
			ctrlSel_q[31:0] <= regWrData & IMPL_MASK[31:0];
		end
		`PSM_OFS_CTRL_B:
		begin
			ctrlSel_q[63:32] <= regWrData & IMPL_MASK[63:32];
		end
		`PSM_OFS_CTRL_C:
		begin
			ctrlSel_q[95:64] <= regWrData & IMPL_MASK[95:64];
		end
		`PSM_OFS_CTRL_D:
		begin
			ctrlSel_q[127:96] <= regWrData & IMPL_MASK[127:96];
		end
		`PSM_OFS_DIR_A:
		begin
			lineDir_q[31:0] <= regWrData & IMPL_MASK[31:0];
		end
		`PSM_OFS_DIR_B:
		begin
			lineDir_q[63:32] <= regWrData & IMPL_MASK[63:32];
		end
		`PSM_OFS_DIR_C:
		begin
			lineDir_q[95:64] <= regWrData & IMPL_MASK[95:64];
		end
		`PSM_OFS_DIR_D:
		begin
			lineDir_q[127:96] <= regWrData & IMPL_MASK[127:96];
		end
		`PSM_OFS_DOUT_A:
		begin
			dataOut_q[31:0] <= regWrData & GPIO_MASK[31:0];
		end
		`PSM_OFS_DOUT_B:
		begin
			dataOut_q[63:32] <= regWrData & GPIO_MASK[63:32];
		end
		`PSM_OFS_DOUT_C:
		begin
			dataOut_q[95:64] <= regWrData & GPIO_MASK[95:64];
		end
		`PSM_OFS_DOUT_D:
		begin
			dataOut_q[127:96] <= regWrData & GPIO_MASK[127:96];
		end
		`PSM_OFS_IRQEN_A:
		begin
			irqEnA_q <= regWrData & `PSM_IRQ_A;
		end
		`PSM_OFS_CHIPCFG:
		begin
			portaAltSel_q <= regWrData[`PSM_BIT_PORTA_ALT];
			portdAltSel_q <= regWrData[`PSM_BIT_PORTD_ALT];
		end
		default:
		begin
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////

// Straps live in the power-on reset domain alone: clearing them with rst_n
// would zero them on every hard reset with no resample, as only powerOnResetN re-arms porPrev_q.
always @(posedge clk or negedge powerOnResetN)
begin
	if (!powerOnResetN)
	begin
		porPrev_q <= 1'b0;
		strap_q <= {4{`PSM_RST_WORD}};
	end
	else
	begin
		porPrev_q <= 1'b1;
		if (!porPrev_q)
			strap_q <= pinIn & STRAP_MASK;
	end
end

////////////////////////////////////////////////////////////////////////////////

genvar gi;
generate
	for (gi = 0; gi < 128; gi = gi + 1)
	begin : gLine
		wire isNmi = (gi == `PSM_NMI_BIT);
		wire swMode = ~ctrlSel_q[gi];
		wire hwMode = ctrlSel_q[gi];
		wire irqEn = (gi < 32) ? irqEnA_q[gi % 32] : 1'b0;
		wire altOn = (gi < 32) ? portaAltSel_q : ((gi >= 96) ? portdAltSel_q : 1'b0);
		wire altSel = hwMode & altOn & ALT_MASK[gi] & ~isNmi;
		wire priSel = hwMode & ~altSel & IMPL_MASK[gi] & ~isNmi;
		wire outSel = swMode & lineDir_q[gi] & GPIO_MASK[gi] & ~isNmi;
		wire inSel = swMode & ~lineDir_q[gi] & ~irqEn & GPIO_MASK[gi];
		wire irqSel = swMode & ~lineDir_q[gi] & irqEn;
		assign pinOut[gi] = altSel ? altOut[gi] : (priSel ? periphOut[gi] : dataOut_q[gi]);
		// Reserved selections never drive the pad
		assign pinOe[gi] = altSel ? altOe[gi] : (priSel ? periphOe[gi] : outSel);
		assign periphIn[gi] = priSel & pinIn[gi];
		assign altIn[gi] = altSel & pinIn[gi];
		assign pinValue[gi] = (inSel & pinIn[gi]) | (outSel & dataOut_q[gi]);
		if (gi < 32)
		begin : gIrq
			assign irqNext[gi] = irqSel & pinIn[gi];
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		irqLine <= 32'h00000000;
		nmiLine <= 1'b0;
	end
	else
	begin
		irqLine <= irqNext;
		nmiLine <= pinIn[`PSM_NMI_BIT];
	end
end

always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
		regRdData <= 32'h00000000;
	else if (regRdEn)
		regRdData <= rdWord;
	else
		regRdData <= 32'h00000000;
end

////////////////////////////////////////////////////////////////////////////////

// Read decode kept apart from the flop so the port only ever shows a word
// in the single cycle after the strobe.
always @*
begin
	rdWord = 32'h00000000;
	case (regAddr)
	`PSM_OFS_CTRL_A:
	begin
		rdWord = ctrlSel_q[31:0];
	end
	`PSM_OFS_CTRL_B:
	begin
		rdWord = ctrlSel_q[63:32];
	end
	`PSM_OFS_CTRL_C:
	begin
		rdWord = ctrlSel_q[95:64];
	end
	`PSM_OFS_CTRL_D:
	begin
		rdWord = ctrlSel_q[127:96];
	end
	`PSM_OFS_DIR_A:
	begin
		rdWord = lineDir_q[31:0];
	end
	`PSM_OFS_DIR_B:
	begin
		rdWord = lineDir_q[63:32];
	end
	`PSM_OFS_DIR_C:
	begin
		rdWord = lineDir_q[95:64];
	end
	`PSM_OFS_DIR_D:
	begin
		rdWord = lineDir_q[127:96];
	end
	`PSM_OFS_DOUT_A:
	begin
		rdWord = dataOut_q[31:0];
	end
	`PSM_OFS_DOUT_B:
	begin
		rdWord = dataOut_q[63:32];
	end
	`PSM_OFS_DOUT_C:
	begin
		rdWord = dataOut_q[95:64];
	end
	`PSM_OFS_DOUT_D:
	begin
		rdWord = dataOut_q[127:96];
	end
	`PSM_OFS_PIN_A:
	begin
		rdWord = pinValue[31:0];
	end
	`PSM_OFS_PIN_B:
	begin
		rdWord = pinValue[63:32];
	end
	`PSM_OFS_PIN_C:
	begin
		rdWord = pinValue[95:64];
	end
	`PSM_OFS_PIN_D:
	begin
		rdWord = pinValue[127:96];
	end
	`PSM_OFS_IRQEN_A:
	begin
		rdWord = irqEnA_q;
	end
	`PSM_OFS_CHIPCFG:
	begin
		rdWord = {30'h0, portdAltSel_q, portaAltSel_q};
	end
	`PSM_OFS_STRAP_A:
	begin
		rdWord = strap_q[31:0];
	end
	`PSM_OFS_STRAP_B:
	begin
		rdWord = strap_q[63:32];
	end
	`PSM_OFS_STRAP_C:
	begin
		rdWord = strap_q[95:64];
	end
	`PSM_OFS_STRAP_D:
	begin
		rdWord = strap_q[127:96];
	end
	default:
	begin
		rdWord = 32'h00000000;
	end
	endcase
end

endmodule

// ### rtl/psm_port_mux_consts.vh
// Constants for the port signal multiplexer: register offsets, reset values,
// field positions and per-port line masks.
// Assumes a 32-bit register port with byte addresses, one word per register.
`ifndef PSM_PORT_MUX_CONSTS_VH
`define PSM_PORT_MUX_CONSTS_VH

`define PSM_ADDR_W 8
`define PSM_OFS_CTRL_A 8'h00
`define PSM_OFS_CTRL_B 8'h04
`define PSM_OFS_CTRL_C 8'h08
`define PSM_OFS_CTRL_D 8'h0C
`define PSM_OFS_DIR_A 8'h10
`define PSM_OFS_DIR_B 8'h14
`define PSM_OFS_DIR_C 8'h18
`define PSM_OFS_DIR_D 8'h1C
`define PSM_OFS_DOUT_A 8'h20
`define PSM_OFS_DOUT_B 8'h24
`define PSM_OFS_DOUT_C 8'h28
`define PSM_OFS_DOUT_D 8'h2C
`define PSM_OFS_PIN_A 8'h30
`define PSM_OFS_PIN_B 8'h34
`define PSM_OFS_PIN_C 8'h38
`define PSM_OFS_PIN_D 8'h3C
`define PSM_OFS_IRQEN_A 8'h40
`define PSM_OFS_CHIPCFG 8'h44
`define PSM_OFS_STRAP_A 8'h48
`define PSM_OFS_STRAP_B 8'h4C
`define PSM_OFS_STRAP_C 8'h50
`define PSM_OFS_STRAP_D 8'h54

`define PSM_BIT_PORTA_ALT 0
`define PSM_BIT_PORTD_ALT 1

`define PSM_RST_WORD 32'h00000000

`define PSM_NMI_BIT 18
`define PSM_IMPL_A 32'h3FFFFFFF
`define PSM_IMPL_B 32'h00007FFF
`define PSM_IMPL_C 32'h0000FFFF
`define PSM_IMPL_D_LATE 32'h000001F4
`define PSM_IMPL_D_EARLY 32'h00000074
`define PSM_GPIO_A 32'h3FFBFFFF
`define PSM_GPIO_B_LATE 32'h00000800
`define PSM_GPIO_B_EARLY 32'h00000000
`define PSM_GPIO_C_LATE 32'h0000C8FF
`define PSM_GPIO_C_EARLY 32'h0000C0FF
`define PSM_GPIO_D_LATE 32'h000001F0
`define PSM_GPIO_D_EARLY 32'h00000070
`define PSM_IRQ_A 32'h3FFBFDBF
`define PSM_ALT_A 32'h00020000
`define PSM_ALT_D 32'h00000000
`define PSM_STRAP_A 32'h00010000
`define PSM_STRAP_B 32'h00000100
`define PSM_STRAP_C 32'h0000C000
`define PSM_STRAP_D_LATE 32'h00000184
`define PSM_STRAP_D_EARLY 32'h00000004

`endif

// ### verif/psm_port_mux_checker.sv
// Port-level assertions for the port line multiplexer.
// Assumes it is bound to the top module and uses the shared masks header.
`timescale 1ns/1ps
`include "psm_port_mux_consts.vh"
module psm_port_mux_checker #(
	parameter LATE_REV = 1
)(
	input wire clk,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrEn,
	input wire [127:0] pinIn,
	input wire [127:0] pinOe,
	input wire [127:0] periphOe,
	input wire [127:0] altOe,
	input wire [127:0] periphIn,
	input wire [127:0] altIn,
	input wire [31:0] irqLine,
	input wire nmiLine
);
	localparam [127:0] IMPL = {LATE_REV ? `PSM_IMPL_D_LATE : `PSM_IMPL_D_EARLY,
		`PSM_IMPL_C, `PSM_IMPL_B, `PSM_IMPL_A};
	localparam [127:0] GPIO = {LATE_REV ? `PSM_GPIO_D_LATE : `PSM_GPIO_D_EARLY,
		LATE_REV ? `PSM_GPIO_C_LATE : `PSM_GPIO_C_EARLY,
		LATE_REV ? `PSM_GPIO_B_LATE : `PSM_GPIO_B_EARLY, `PSM_GPIO_A};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence hwLineA0;
		regWrEn && regAddr == `PSM_OFS_CTRL_A && regWrData[0];
	endsequence
	////////////////////////////////////////////////////////////////////////
	chk_nmi_undriven: assert property (!pinOe[18])
		else $error("nmi pad driven");
	chk_nmi_copy: assert property (rst_n [*2] |-> nmiLine == $past(pinIn[18]))
		else $error("nmi line not following pad");
	chk_unimpl_quiet: assert property (((pinOe | periphIn | altIn) & ~IMPL) == 0)
		else $error("unimplemented line active");
	chk_sw_drive_gpio: assert property ((pinOe & ~GPIO & ~periphOe & ~altOe) == 0)
		else $error("non gpio line driven by software");
	chk_alt_a17_only: assert property ((altIn & ~{96'h0, `PSM_ALT_A}) == 0)
		else $error("alternate input on wrong line");
	chk_prim_alt_excl: assert property ((periphIn & altIn) == 0)
		else $error("primary and alternate both fed");
	chk_irq_capable: assert property ((irqLine & ~`PSM_IRQ_A) == 0)
		else $error("interrupt on incapable line");
	chk_hw_route: assert property (hwLineA0 |=> pinOe[0] == periphOe[0])
		else $error("hardware routing late");
	chk_hw_no_irq: assert property (hwLineA0 |-> ##2 !irqLine[0])
		else $error("interrupt kept in hardware mode");
	chk_reset_input: assert property ($rose(rst_n) |-> pinOe == 0)
		else $error("pad driven after reset");
endmodule

// ### verif/psm_board_model.sv
// Board side of the pads: drives levels where the bench asks, floats elsewhere.
// Assumes boardEn and boardLvl come from the bench.
`timescale 1ns/1ps
module psm_board_model(
	input wire clk,
	input wire [127:0] pinOut,
	input wire [127:0] pinOe,
	input wire [127:0] boardEn,
	input wire [127:0] boardLvl,
	output wire [127:0] pinIn
);
	// No pulls here, so a floating pad must never look like a held level
	reg [127:0] floatQ = {64{2'b01}};
	always @(posedge clk)
		floatQ <= ~floatQ;
	assign pinIn = (pinOe & pinOut) | (~pinOe & ((boardEn & boardLvl) | (~boardEn & floatQ)));
endmodule

// ### verif/tb_psm_port_mux.sv
// Self-checking bench for the port line multiplexer.
// Assumes the late revision and the register map of the constants header.
`timescale 1ns/1ps
`include "psm_port_mux_consts.vh"
module tb_psm_port_mux;
	localparam [127:0] IMPL = {`PSM_IMPL_D_LATE, `PSM_IMPL_C, `PSM_IMPL_B, `PSM_IMPL_A};
	localparam [127:0] STRAP = {`PSM_STRAP_D_LATE, `PSM_STRAP_C, `PSM_STRAP_B, `PSM_STRAP_A};
	reg clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, powerOnResetN = 0, rdSeen = 0;
	reg [7:0] regAddr = 8'h00;
	reg [31:0] regWrData = 32'h0, r;
	reg [127:0] periphOut = 0, periphOe = 0, altOut = 0, altOe = 0, boardEn = 0, boardLvl = 0, s;
	wire [31:0] regRdData, irqLine;
	wire [127:0] pinIn, pinOut, pinOe, periphIn, altIn;
	wire nmiLine;
	integer seed = 32'h3569069D, fails = 0, compares = 0, i;
	reg [31:0] expQ[$], mskQ[$];
	psm_port_mux #(.LATE_REV(1)) psm_port_mux_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.powerOnResetN(powerOnResetN), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn), .altOut(altOut),
		.altOe(altOe), .altIn(altIn), .irqLine(irqLine), .nmiLine(nmiLine));
	psm_board_model psm_board_model_inst (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
		.boardEn(boardEn), .boardLvl(boardLvl), .pinIn(pinIn));
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		periphOut <= {4{$random(seed)}};
		periphOe <= {4{$random(seed)}};
		altOut <= {4{$random(seed)}};
		altOe <= {4{$random(seed)}};
		if (rdSeen)
			cmp({96'h0, regRdData & mskQ.pop_front()}, {96'h0, expQ.pop_front()});
		rdSeen <= regRdEn;
	end
	////////////////////////////////////////////////////////////////////////
	task cmp(input [127:0] got, input [127:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp)
			begin
				fails = fails + 1;
				$display("[ERR] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			regAddr <= a;
			regWrData <= d;
			regWrEn <= 1'b1;
			@(posedge clk);
			regWrEn <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		begin
			expQ.push_back(e & m);
			mskQ.push_back(m);
			@(posedge clk);
			regAddr <= a;
			regRdEn <= 1'b1;
			@(posedge clk);
			regRdEn <= 1'b0;
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		boardEn = {128{1'b1}};
		boardLvl = {4{$random(seed)}};
		s = boardLvl;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		powerOnResetN <= 1'b1;
		for (i = 0; i < 14; i = i + 1)
			rd(8'(i < 12 ? i * 4 : i * 4 + 16), 32'h0, 32'hFFFFFFFF);
		boardLvl <= ~s;
		// Straps must keep the level seen at release, not the new one
		for (i = 0; i < 4; i = i + 1)
		begin
			rd(8'(72 + 4 * i), s[32 * i +: 32], STRAP[32 * i +: 32]);
			wr(8'(4 * i), 32'hFFFFFFFF);
			rd(8'(4 * i), IMPL[32 * i +: 32], 32'hFFFFFFFF);
		end
		$display("reset defaults and straps done");
		tick(1);
		cmp(pinOe, periphOe & IMPL & ~(128'h1 << 18));
		cmp(periphIn, pinIn & IMPL & ~(128'h1 << 18));
		wr(`PSM_OFS_CHIPCFG, 32'h3);
		tick(1);
		cmp(128'({pinOe[17], pinOut[17], altIn[17], periphIn[17]}), 128'({altOe[17], altOut[17], pinIn[17], 1'b0}));
		rd(`PSM_OFS_CHIPCFG, 32'h3, 32'hFFFFFFFF);
		$display("hardware routing done");
		r = $random(seed);
		wr(`PSM_OFS_CTRL_A, 32'h0);
		wr(`PSM_OFS_DIR_A, 32'hFFFFFFFF);
		wr(`PSM_OFS_DOUT_A, r);
		tick(1);
		cmp(128'({pinOe[31:0], pinOut[31:0] & `PSM_GPIO_A}), 128'({`PSM_GPIO_A, r & `PSM_GPIO_A}));
		rd(`PSM_OFS_PIN_A, r, `PSM_GPIO_A);
		wr(`PSM_OFS_DIR_A, 32'h0);
		rd(`PSM_OFS_PIN_A, ~s[31:0], `PSM_GPIO_A);
		$display("software lines done");
		wr(`PSM_OFS_IRQEN_A, 32'hFFFFFFFF);
		tick(1);
		cmp({96'h0, irqLine}, {96'h0, ~s[31:0] & `PSM_IRQ_A});
		rd(`PSM_OFS_PIN_A, ~s[31:0] & ~`PSM_IRQ_A, `PSM_GPIO_A);
		wr(`PSM_OFS_DIR_A, 32'hFFFFFFFF);
		tick(1);
		cmp({96'h0, irqLine}, 128'h0);
		wr(`PSM_OFS_DIR_A, 32'h0);
		wr(`PSM_OFS_CTRL_A, 32'h1);
		tick(1);
		cmp({96'h0, irqLine}, {96'h0, ~s[31:0] & `PSM_IRQ_A & 32'hFFFFFFFE});
		$display("interrupt lines done");
		// Hard reset alone restores defaults but must leave the straps alone
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		cmp(pinOe, 128'h0);
		rd(`PSM_OFS_CTRL_A, 32'h0, 32'hFFFFFFFF);
		rd(`PSM_OFS_STRAP_D, s[127:96], STRAP[127:96]);
		rd(`PSM_OFS_PIN_B, ~s[63:32] & `PSM_GPIO_B_LATE, 32'hFFFFFFFF);
		$display("hard reset done");
		wr(8'h80, 32'hFFFFFFFF);
		rd(8'h80, 32'h0, 32'hFFFFFFFF);
		tick(3);
		$display("unmapped access done");
		finish_test;
	end
	initial
	begin
		#100000;
		fails = fails + 1;
		finish_test;
	end
endmodule
bind psm_port_mux psm_port_mux_checker #(.LATE_REV(LATE_REV)) psm_port_mux_checker_inst (
	.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
	.pinIn(pinIn), .pinOe(pinOe), .periphOe(periphOe), .altOe(altOe), .periphIn(periphIn),
	.altIn(altIn), .irqLine(irqLine), .nmiLine(nmiLine));
